// file: core/analog_input_diagnostic_record.sv
// Diagnostic record of the two-channel analog voltage input module.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - The block has no interrupt output; diagnostics are the readable record bytes and the channel indicators.
// - An error on a channel lights that channel's indicator and is entered in the record.
// - Parameter faults, range overflow and range underflow are detected and recorded.
// - Record set 01h returns the whole record and record set 00h its first four bytes.
// - CANopen index 2F01h returns the whole record and index 2F00h its first four bytes.
// - EtherCAT object 5005h reaches each record byte or field by its own subindex.
// - First summary byte bits 0 to 3 flag module failure, internal, external and channel error.
// - First summary byte bit 4 flags missing auxiliary supply and bit 7 a parameter error.
// - Module information bits 3 to 0 hold class 0101b for an analog module.
// - Module information bit 4 marks channel information present, giving the value 15h.
// - Second summary byte bit 3 flags an internal diagnostics buffer overflow.
// - Second summary byte bit 4 flags an internal communication error.
module analog_input_diagnostic_record
    import diag_record_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Error conditions from the measuring logic.
    input wire error_in_t err_in,
    // Record read port towards the bus coupler.
    input wire read_req_t rd_req,
    output var read_resp_t rd_resp,
    // Channel indicators.
    output logic [NUM_CH-1:0] ch_led
);

    typedef struct packed {
        logic [31:0] ticker;
        logic [7:0] prescale;
        logic [7:0] summary_first;
        logic [7:0] summary_second;
        logic [7:0] ch_summary;
        logic [NUM_CH-1:0][7:0] ch_err;
        logic [NUM_CH-1:0] led;
        read_resp_t resp;
    } state_t;

    state_t st_reg;
    state_t st_next;
    logic [NUM_CH-1:0][7:0] ch_err_now;
    logic [RECORD_BYTES-1:0][7:0] record;

    // ****************************************
    // Channel error bytes
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            always_comb
            begin
                ch_err_now[gi] = ZERO_BYTE;
                ch_err_now[gi][BIT_CH_PARAM] = err_in.ch_param_fault[gi];
                ch_err_now[gi][BIT_CH_OVERFLOW] = err_in.ch_overflow[gi];
                ch_err_now[gi][BIT_CH_UNDERFLOW] = err_in.ch_underflow[gi];
            end
        end
    endgenerate

    // ****************************************
    // Record image
    // ****************************************
    always_comb
    begin
        record = '0;
        record[OFS_SUMMARY_FIRST] = st_reg.summary_first;
        record[OFS_MODULE_INFO] = MODULE_INFO_VAL;
        record[OFS_RESERVED_THIRD] = ZERO_BYTE;
        record[OFS_SUMMARY_SECOND] = st_reg.summary_second;
        record[OFS_CHANNEL_KIND] = CHANNEL_KIND_VAL;
        record[OFS_BITS_PER_CH] = BITS_PER_CH_VAL;
        record[OFS_CHANNEL_COUNT] = CHANNEL_COUNT_VAL;
        record[OFS_CH_SUMMARY] = st_reg.ch_summary;
        for (int i = 0; i < NUM_CH; i++)
        begin
            record[OFS_CH_ERRORS + i] = st_reg.ch_err[i];
        end
        for (int i = 0; i < 4; i++)
        begin
            record[OFS_TICKER + i] = st_reg.ticker[8*i +: 8];
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic hit;
        logic [4:0] idx;
        logic [4:0] limit;
        st_next = st_reg;
        hit = 1'b0;
        idx = 5'h00;
        limit = 5'h00;
        // Microsecond ticker.
        if (st_reg.prescale == TICK_CYCLES - 8'h01)
        begin
            st_next.prescale = 8'h00;
            st_next.ticker = st_reg.ticker + 32'h0000_0001;
        end
        else
        begin
            st_next.prescale = st_reg.prescale + 8'h01;
        end
        // Channel errors, summaries and indicators.
        st_next.ch_err = ch_err_now;
        st_next.ch_summary = ZERO_BYTE;
        for (int i = 0; i < NUM_CH; i++)
        begin
            st_next.ch_summary[i] = |ch_err_now[i];
        end
        st_next.led = st_next.ch_summary[NUM_CH-1:0];
        st_next.summary_first = ZERO_BYTE;
        st_next.summary_first[BIT_MODULE_FAIL] = err_in.module_failure;
        st_next.summary_first[BIT_INTERNAL_ERR] = err_in.internal_error;
        st_next.summary_first[BIT_EXTERNAL_ERR] = err_in.external_error;
        st_next.summary_first[BIT_CHANNEL_ERR] = |st_next.ch_summary;
        st_next.summary_first[BIT_AUX_MISSING] = err_in.aux_supply_missing;
        st_next.summary_first[BIT_PARAM_ERR] = err_in.param_error
            | (|err_in.ch_param_fault);
        st_next.summary_second = ZERO_BYTE;
        st_next.summary_second[BIT_DIAG_OVERFLOW] = err_in.diag_buffer_overflow;
        st_next.summary_second[BIT_COMM_ERR] = err_in.internal_comm_error;
        // Record read decode.
        if (rd_req.kind == ACCESS_RECSET && rd_req.key == RECSET_FULL)
        begin
            limit = FULL_RECORD_BYTES;
        end
        else if (rd_req.kind == ACCESS_RECSET && rd_req.key == RECSET_SHORT)
        begin
            limit = SHORT_RECORD_BYTES;
        end
        else if (rd_req.kind == ACCESS_CANOPEN && rd_req.key == CANOPEN_FULL)
        begin
            limit = FULL_RECORD_BYTES;
        end
        else if (rd_req.kind == ACCESS_CANOPEN && rd_req.key == CANOPEN_SHORT)
        begin
            limit = SHORT_RECORD_BYTES;
        end
        if (limit != 5'h00)
        begin
            hit = rd_req.byte_sel < limit;
            idx = rd_req.byte_sel;
        end
        else if (rd_req.kind == ACCESS_ETHERCAT && rd_req.key == ETHERCAT_OBJECT)
        begin
            if (rd_req.subindex >= SUB_FIRST && rd_req.subindex <= SUB_LAST_BYTE)
            begin
                hit = 1'b1;
                idx = 5'(rd_req.subindex - SUB_FIRST);
            end
            else if (rd_req.subindex == SUB_TICKER && rd_req.byte_sel < 5'h04)
            begin
                hit = 1'b1;
                idx = TICKER_BYTE_OFS + rd_req.byte_sel;
            end
        end
        st_next.resp.valid = rd_req.valid;
        st_next.resp.error = rd_req.valid & ~hit;
        st_next.resp.data = (rd_req.valid && hit) ? record[idx] : ZERO_BYTE;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rd_resp = st_reg.resp;
    assign ch_led = st_reg.led;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_led_on_error: assert property (err_in.ch_overflow[0] |=> ch_led[0])
        else $error("Channel 0 indicator not lit after overflow.");
    a_led_on_param: assert property (err_in.ch_param_fault[1] |=> ch_led[1])
        else $error("Channel 1 indicator not lit after parameter fault.");
    a_led_clears: assert property (
        err_in.ch_param_fault[1] == 1'b0 && err_in.ch_overflow[1] == 1'b0
        && err_in.ch_underflow[1] == 1'b0 |=> !ch_led[1])
        else $error("Channel 1 indicator lit without an error.");
    a_underflow_recorded: assert property (
        err_in.ch_underflow[1]
        |=> st_reg.ch_err[1][BIT_CH_UNDERFLOW] && st_reg.summary_first[BIT_CHANNEL_ERR])
        else $error("Channel 1 underflow not recorded.");
    a_overflow_recorded: assert property (
        err_in.ch_overflow[1] |=> st_reg.ch_err[1][BIT_CH_OVERFLOW])
        else $error("Channel 1 overflow not recorded.");
    a_fault_recorded: assert property (
        err_in.ch_param_fault[0] |=> st_reg.ch_err[0][BIT_CH_PARAM])
        else $error("Channel 0 parameter fault not recorded.");
    a_resp_follows: assert property (rd_req.valid |=> rd_resp.valid)
        else $error("Read request not answered in the next cycle.");
    a_resp_quiet: assert property (
        !rd_req.valid |=> !rd_resp.valid && !rd_resp.error && rd_resp.data == ZERO_BYTE)
        else $error("Answer seen without a request.");
    a_short_record_limit: assert property (
        rd_req.valid && rd_req.kind == ACCESS_RECSET && rd_req.key == RECSET_SHORT
        && rd_req.byte_sel >= 5'h04 |=> rd_resp.error)
        else $error("Short record set served past its fourth byte.");
    a_full_record_hit: assert property (
        rd_req.valid && rd_req.kind == ACCESS_RECSET && rd_req.key == RECSET_FULL
        && rd_req.byte_sel < 5'h14 |=> rd_resp.valid && !rd_resp.error)
        else $error("Full record set byte refused.");
    a_error_data_zero: assert property (
        rd_resp.error |-> rd_resp.valid && rd_resp.data == ZERO_BYTE)
        else $error("Refused read carries data.");
    a_canopen_modinfo: assert property (
        rd_req.valid && rd_req.kind == ACCESS_CANOPEN && rd_req.key == CANOPEN_FULL
        && rd_req.byte_sel == 5'h01
        |=> rd_resp.valid && !rd_resp.error && rd_resp.data == 8'h15)
        else $error("Module information not read back as 15h.");
    a_canopen_short_limit: assert property (
        rd_req.valid && rd_req.kind == ACCESS_CANOPEN && rd_req.key == CANOPEN_SHORT
        && rd_req.byte_sel >= 5'h04 |=> rd_resp.error)
        else $error("Short CANopen index served past its fourth byte.");
    a_ethercat_kind: assert property (
        rd_req.valid && rd_req.kind == ACCESS_ETHERCAT && rd_req.key == ETHERCAT_OBJECT
        && rd_req.subindex == 8'h06 |=> !rd_resp.error && rd_resp.data == 8'h71)
        else $error("Channel kind subindex returned a wrong value.");
    a_ethercat_bytes: assert property (
        rd_req.valid && rd_req.kind == ACCESS_ETHERCAT && rd_req.key == ETHERCAT_OBJECT
        && rd_req.subindex >= SUB_FIRST && rd_req.subindex <= SUB_LAST_BYTE
        |=> rd_resp.valid && !rd_resp.error)
        else $error("Mapped EtherCAT subindex refused.");
    a_ethercat_gap: assert property (
        rd_req.valid && rd_req.kind == ACCESS_ETHERCAT && rd_req.subindex == 8'h12
        |=> rd_resp.error)
        else $error("Unmapped EtherCAT subindex answered.");
    a_first_byte_bits: assert property (
        err_in.module_failure && err_in.aux_supply_missing
        |=> st_reg.summary_first[0] && st_reg.summary_first[4])
        else $error("Module failure or supply missing bit not set.");
    a_internal_external: assert property (
        err_in.internal_error && err_in.external_error
        |=> st_reg.summary_first[1] && st_reg.summary_first[2])
        else $error("Internal or external error bit not set.");
    a_param_bit: assert property (err_in.ch_param_fault[1] |=> st_reg.summary_first[7])
        else $error("Parameter error bit not set.");
    a_module_info_read: assert property (
        rd_req.valid && rd_req.kind == ACCESS_ETHERCAT && rd_req.key == ETHERCAT_OBJECT
        && rd_req.subindex == 8'h03 |=> rd_resp.data == MODULE_INFO_VAL)
        else $error("Module information subindex returned a wrong value.");
    a_second_byte_bits: assert property (
        err_in.diag_buffer_overflow && !err_in.internal_comm_error
        |=> st_reg.summary_second == 8'h08)
        else $error("Second summary byte wrong after buffer overflow.");
    a_comm_error_bit: assert property (
        err_in.internal_comm_error
        |=> st_reg.summary_second[4])
        else $error("Communication error bit not set.");
    a_channel_summary: assert property (
        st_reg.summary_first[3]
        == (st_reg.ch_err[0] != 8'h00 || st_reg.ch_err[1] != 8'h00))
        else $error("Channel error bit disagrees with channel bytes.");
    a_summary_clear: assert property (
        err_in == '0 |=> st_reg.ch_summary == ZERO_BYTE && !st_reg.summary_first[3])
        else $error("Channel error bits stay set without errors.");
    a_reserved_zero: assert property (
        st_reg.summary_first[6:5] == 2'b00
        && st_reg.summary_second[2:0] == 3'b000 && st_reg.summary_second[7:5] == 3'b000)
        else $error("Reserved bit reads nonzero.");
    a_reserved_third: assert property (
        rd_req.valid && rd_req.kind == ACCESS_RECSET && rd_req.key == RECSET_FULL
        && rd_req.byte_sel == 5'h02 |=> rd_resp.data == ZERO_BYTE)
        else $error("Reserved third byte reads nonzero.");
    a_ticker_step: assert property (st_reg.prescale == TICK_CYCLES - 8'h01
        |=> st_reg.ticker == $past(st_reg.ticker) + 32'h0000_0001)
        else $error("Ticker did not advance after 200 cycles.");
    a_ticker_hold: assert property (st_reg.prescale != TICK_CYCLES - 8'h01
        |=> $stable(st_reg.ticker))
        else $error("Ticker moved between microsecond steps.");
    a_prescale_range: assert property (st_reg.prescale < TICK_CYCLES)
        else $error("Prescaler left its range.");

    c_full_read: cover property (rd_req.valid && rd_req.kind == ACCESS_RECSET
        && rd_req.key == RECSET_FULL ##1 rd_resp.valid && !rd_resp.error);
    c_ethercat_ticker: cover property (rd_req.valid && rd_req.kind == ACCESS_ETHERCAT
        && rd_req.subindex == SUB_TICKER ##1 !rd_resp.error);
    c_both_leds: cover property (ch_led == 2'b11);
    c_unmapped: cover property (rd_resp.valid && rd_resp.error);
    c_led_handover: cover property (ch_led == 2'b01 ##1 ch_led == 2'b10);

endmodule // analog_input_diagnostic_record

`default_nettype wire

// file: core/diag_record_pkg.sv
// Constants and carrier types of the analog input diagnostic record.
package diag_record_pkg;
    // Clock and microsecond ticker timing.
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_PERIOD_NS = 1000;
    localparam logic [7:0] TICK_CYCLES = 8'(TICK_PERIOD_NS / CLK_PERIOD_NS);
    // Channels and record size.
    localparam int NUM_CH = 2;
    localparam int RECORD_BYTES = 20;
    localparam logic [4:0] SHORT_RECORD_BYTES = 5'h04;
    localparam logic [4:0] FULL_RECORD_BYTES = 5'h14;
    // Record numbers, CANopen indexes and the EtherCAT object.
    localparam logic [15:0] RECSET_SHORT = 16'h0000;
    localparam logic [15:0] RECSET_FULL = 16'h0001;
    localparam logic [15:0] CANOPEN_SHORT = 16'h2f00;
    localparam logic [15:0] CANOPEN_FULL = 16'h2f01;
    localparam logic [15:0] ETHERCAT_OBJECT = 16'h5005;
    // EtherCAT subindexes.
    localparam logic [7:0] SUB_FIRST = 8'h02;
    localparam logic [7:0] SUB_LAST_BYTE = 8'h11;
    localparam logic [7:0] SUB_TICKER = 8'h13;
    // Byte offsets inside the record.
    localparam int OFS_SUMMARY_FIRST = 0;
    localparam int OFS_MODULE_INFO = 1;
    localparam int OFS_RESERVED_THIRD = 2;
    localparam int OFS_SUMMARY_SECOND = 3;
    localparam int OFS_CHANNEL_KIND = 4;
    localparam int OFS_BITS_PER_CH = 5;
    localparam int OFS_CHANNEL_COUNT = 6;
    localparam int OFS_CH_SUMMARY = 7;
    localparam int OFS_CH_ERRORS = 8;
    localparam int OFS_TICKER = 16;
    localparam logic [4:0] TICKER_BYTE_OFS = 5'h10;
    // Fixed and reset values.
    localparam logic [7:0] MODULE_INFO_VAL = 8'h15;
    localparam logic [7:0] CHANNEL_KIND_VAL = 8'h71;
    localparam logic [7:0] BITS_PER_CH_VAL = 8'h08;
    localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h02;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Bit positions of the first and second summary bytes.
    localparam int BIT_MODULE_FAIL = 0;
    localparam int BIT_INTERNAL_ERR = 1;
    localparam int BIT_EXTERNAL_ERR = 2;
    localparam int BIT_CHANNEL_ERR = 3;
    localparam int BIT_AUX_MISSING = 4;
    localparam int BIT_PARAM_ERR = 7;
    localparam int BIT_DIAG_OVERFLOW = 3;
    localparam int BIT_COMM_ERR = 4;
    // Bit positions of a channel error byte.
    localparam int BIT_CH_PARAM = 0;
    localparam int BIT_CH_OVERFLOW = 1;
    localparam int BIT_CH_UNDERFLOW = 2;

    typedef enum logic [1:0] {ACCESS_RECSET, ACCESS_CANOPEN, ACCESS_ETHERCAT} access_kind_t;

    typedef struct packed {
        logic module_failure;
        logic internal_error;
        logic external_error;
        logic aux_supply_missing;
        logic param_error;
        logic diag_buffer_overflow;
        logic internal_comm_error;
        logic [NUM_CH-1:0] ch_param_fault;
        logic [NUM_CH-1:0] ch_overflow;
        logic [NUM_CH-1:0] ch_underflow;
    } error_in_t;

    typedef struct packed {
        logic valid;
        access_kind_t kind;
        logic [15:0] key;
        logic [7:0] subindex;
        logic [4:0] byte_sel;
    } read_req_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [7:0] data;
    } read_resp_t;
endpackage

// file: dv/analog_input_diagnostic_record_tb_top.sv
// Self-checking testbench of the analog input diagnostic record.
`timescale 1ns/1ps
`default_nettype none

module analog_input_diagnostic_record_tb_top
    import diag_record_pkg::*;
();
    localparam access_kind_t RS = ACCESS_RECSET;
    localparam access_kind_t CO = ACCESS_CANOPEN;
    localparam access_kind_t EC = ACCESS_ETHERCAT;
    typedef struct packed {
        access_kind_t kind;
        logic [15:0] key;
        logic [7:0] sub;
        logic [4:0] sel;
        error_in_t err;
        logic [7:0] data;
        logic bad;
        logic [1:0] led;
    } row_t;
    row_t rows [0:34] = '{
        '{RS, 16'h0001, 8'h00, 5'h01, 13'h0000, 8'h15, 1'b0, 2'h0},
        '{CO, 16'h2f01, 8'h00, 5'h04, 13'h0000, 8'h71, 1'b0, 2'h0},
        '{EC, 16'h5005, 8'h07, 5'h00, 13'h0000, 8'h08, 1'b0, 2'h0},
        '{EC, 16'h5005, 8'h08, 5'h00, 13'h0000, 8'h02, 1'b0, 2'h0},
        '{EC, 16'h5005, 8'h03, 5'h00, 13'h1fff, 8'h15, 1'b0, 2'h3},
        '{RS, 16'h0000, 8'h00, 5'h03, 13'h0080, 8'h08, 1'b0, 2'h0},
        '{RS, 16'h0000, 8'h00, 5'h04, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{CO, 16'h2f00, 8'h00, 5'h04, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{CO, 16'h2f00, 8'h00, 5'h00, 13'h1000, 8'h01, 1'b0, 2'h0},
        '{RS, 16'h0002, 8'h00, 5'h00, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h14, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{EC, 16'h5005, 8'h12, 5'h00, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{EC, 16'h5005, 8'h13, 5'h04, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{EC, 16'h5006, 8'h02, 5'h00, 13'h0000, 8'h00, 1'b1, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h0800, 8'h02, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h0400, 8'h04, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h0200, 8'h10, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h0100, 8'h80, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h03, 13'h0040, 8'h10, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h08, 13'h0004, 8'h02, 1'b0, 2'h1},
        '{EC, 16'h5005, 8'h09, 5'h00, 13'h0004, 8'h01, 1'b0, 2'h1},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h0004, 8'h08, 1'b0, 2'h1},
        '{EC, 16'h5005, 8'h0b, 5'h00, 13'h0008, 8'h02, 1'b0, 2'h2},
        '{CO, 16'h2f01, 8'h00, 5'h09, 13'h0002, 8'h04, 1'b0, 2'h2},
        '{CO, 16'h2f01, 8'h00, 5'h00, 13'h0020, 8'h88, 1'b0, 2'h2},
        '{RS, 16'h0001, 8'h00, 5'h09, 13'h0020, 8'h01, 1'b0, 2'h2},
        '{RS, 16'h0001, 8'h00, 5'h02, 13'h1fff, 8'h00, 1'b0, 2'h3},
        '{EC, 16'h5005, 8'h0c, 5'h00, 13'h1fff, 8'h00, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h0f, 13'h1fff, 8'h00, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h00, 13'h1fff, 8'h9f, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h03, 13'h1fff, 8'h18, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h07, 13'h1fff, 8'h03, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h08, 13'h1fff, 8'h07, 1'b0, 2'h3},
        '{RS, 16'h0001, 8'h00, 5'h07, 13'h0000, 8'h00, 1'b0, 2'h0},
        '{RS, 16'h0001, 8'h00, 5'h06, 13'h0000, 8'h02, 1'b0, 2'h0}
    };
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    error_in_t err_in = '0;
    read_req_t rd_req;
    read_resp_t rd_resp;
    logic [1:0] ch_led;
    read_resp_t resp;
    logic [7:0] first_tick;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;

    // ****************************************
    // Clock, design and coupler
    // ****************************************
    always #2.5 clk = ~clk;

    analog_input_diagnostic_record uut (.clk(clk), .rst_b(rst_b), .err_in(err_in),
        .rd_req(rd_req), .rd_resp(rd_resp), .ch_led(ch_led));
    coupler_model u_coupler (.clk(clk), .rd_req(rd_req), .rd_resp(rd_resp));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flags(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic read_chk(input access_kind_t k, input logic [15:0] key,
        input logic [7:0] sub, input logic [4:0] sel, input logic [7:0] exp, input logic bad);
        u_coupler.read_byte(k, key, sub, sel, resp);
        check_flags({1'b0, resp.valid}, 2'h1);
        check_flags({1'b0, resp.error}, {1'b0, bad});
        check_data(resp.data, exp);
    endtask

    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        read_chk(RS, 16'h0001, 8'h00, 5'h10, 8'h00, 1'b0);
        @(negedge clk);
        check_flags({1'b0, rd_resp.valid}, 2'h0);
        foreach (rows[i])
        begin
            @(negedge clk);
            err_in = rows[i].err;
            read_chk(rows[i].kind, rows[i].key, rows[i].sub, rows[i].sel,
                rows[i].data, rows[i].bad);
            check_flags(ch_led, rows[i].led);
        end
        // The ticker steps once in any window of 200 clocks.
        u_coupler.read_byte(EC, 16'h5005, 8'h13, 5'h00, resp);
        first_tick = resp.data;
        repeat (198) @(negedge clk);
        u_coupler.read_byte(EC, 16'h5005, 8'h13, 5'h00, resp);
        check_data(resp.data, first_tick + 8'h01);
        // A reset in mid-run clears outputs and ticker while errors stay on.
        err_in = error_in_t'(13'h1fff);
        repeat (2) @(negedge clk);
        rst_b = 1'b0;
        @(negedge clk);
        check_flags(ch_led, 2'h0);
        rst_b = 1'b1;
        read_chk(RS, 16'h0001, 8'h00, 5'h10, 8'h00, 1'b0);
        read_chk(RS, 16'h0001, 8'h00, 5'h03, 8'h18, 1'b0);
        check_flags(ch_led, 2'h3);
        print_verdict();
    end
endmodule // analog_input_diagnostic_record_tb_top

`default_nettype wire

// file: dv/coupler_model.sv
// Bus coupler model that reads the diagnostic record one byte per request.
`timescale 1ns/1ps
`default_nettype none

module coupler_model
    import diag_record_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Record read port.
    output var read_req_t rd_req,
    input wire read_resp_t rd_resp
);
    // ****************************************
    // Idle request
    // ****************************************
    // Fields carry a changing pattern while no request is made.
    initial rd_req = '{valid: 1'b0, kind: ACCESS_RECSET, key: 16'h5a5a, subindex: 8'ha5, byte_sel: 5'h15};

    // ****************************************
    // Byte read
    // ****************************************
    // Requests by record number, CANopen index or EtherCAT object and subindex.
    task automatic read_byte(input access_kind_t kind, input logic [15:0] key,
        input logic [7:0] sub, input logic [4:0] sel, output read_resp_t resp);
        @(negedge clk);
        rd_req <= '{valid: 1'b1, kind: kind, key: key, subindex: sub, byte_sel: sel};
        @(negedge clk);
        resp = rd_resp;
        rd_req.valid <= 1'b0;
        rd_req.key <= ~rd_req.key;
        rd_req.subindex <= ~rd_req.subindex;
        rd_req.byte_sel <= ~rd_req.byte_sel;
    endtask
endmodule // coupler_model

`default_nettype wire
